// ==== hdl/speq_core.sv ====
// How it works
// R1 - Held chip select with mode-fault detection on: master transfers never start.
// R2 - Software sets mode-fault disable when using held chip select.
// R3 - Disabling leaves the transmit-empty flag exactly as it was.
// R4 - Writes while disabled are dropped and leave transmit-empty untouched.
// R5 - Disable during DMA: DMA keeps writing, all those words lost.
// R6 - Software stops DMA first, waits, then disables; re-enables reverse order.
// R7 - In slave operation disable is ignored; block keeps answering master.
// R8 - Slave stop: read last word, then pulse soft reset.
`default_nettype none
module speq_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic soft_reset_bit,
  input wire speq_pkg::speq_cfg_type cfg,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic rd_strobe,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  output logic sck_out,
  output logic sck_oe,
  output logic cs_n_out,
  output logic mosi_out,
  output logic miso_out,
  output logic miso_oe,
  output logic [7:0] rx_data,
  output speq_pkg::speq_stat_type stat
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic sck_s;
  logic cs_n_s;
  logic mosi_s;
  logic miso_s;
  speq_sync u_sck (.mclk(mclk), .rst(rst), .din(sck_in), .dout(sck_s));
  speq_sync u_cs (.mclk(mclk), .rst(rst), .din(cs_n_in), .dout(cs_n_s));
  speq_sync u_mosi (.mclk(mclk), .rst(rst), .din(mosi_in), .dout(mosi_s));
  speq_sync u_miso (.mclk(mclk), .rst(rst), .din(miso_in), .dout(miso_s));

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  speq_pkg::speq_state_type st_q, st_d;
  logic [7:0] hold_q, hold_d;
  logic [7:0] shf_q, shf_d;
  logic [7:0] rx_q, rx_d;
  logic [2:0] cnt_q, cnt_d;
  logic empty_q, empty_d;
  logic rxf_q, rxf_d;
  logic sck_prev_q, sck_prev_d;
  logic sck_o_q, sck_o_d;
  logic cs_o_q, cs_o_d;
  logic en_q, en_d;
  logic mstr_q, mstr_d;
  logic mis_q, mis_d;
  logic start_ok;
  logic active;
  logic rise;
  logic fall;
  logic clr;

  assign clr = rst | soft_reset_bit;
  assign rise = sck_s & ~sck_prev_q;
  assign fall = ~sck_s & sck_prev_q;
  // Held chip select with fault detection never lets a master transfer start
  assign start_ok = ~(cfg.cs_hold_after_transfer & ~cfg.mode_fault_disable); // R1

  always_comb begin
    st_d = st_q;
    hold_d = hold_q;
    shf_d = shf_q;
    rx_d = rx_q;
    cnt_d = cnt_q;
    empty_d = empty_q;
    rxf_d = rxf_q;
    sck_prev_d = sck_s;
    sck_o_d = sck_o_q;
    cs_o_d = cs_o_q;
    mstr_d = mstr_q;
    mis_d = mis_q;
    // Slave mode latches enable; disable cannot take effect there
    if (cfg.enable) begin
      en_d = 1'b1;
      mstr_d = cfg.master;
    end else begin
      en_d = en_q & ~mstr_q; // R7
    end
    active = en_q;
    if (rd_strobe) begin
      rxf_d = 1'b0;
    end
    // Disabled writes vanish; this also swallows a DMA stream (R5)
    if (wr_valid && active) begin // R4 R5
      hold_d = wr_data;
      empty_d = 1'b0;
    end
    // Empty flag is only touched by writes, loads and reset, never by enable (R3)
    unique case (st_q)
      speq_pkg::SPEQ_IDLE: begin
        if (!cfg.cs_hold_after_transfer) begin
          cs_o_d = 1'b1;
        end
        if (active && mstr_q && !empty_q) begin
          if (start_ok) begin // R1
            shf_d = hold_q;
            empty_d = 1'b1;
            cnt_d = 3'h0;
            cs_o_d = 1'b0;
            st_d = speq_pkg::SPEQ_SHIFT;
          end else begin
            st_d = speq_pkg::SPEQ_HANG; // R1
          end
        end else if (active && !mstr_q && !cs_n_s) begin
          shf_d = empty_q ? shf_q : hold_q;
          empty_d = 1'b1;
          cnt_d = 3'h0;
          st_d = speq_pkg::SPEQ_SHIFT;
        end
      end
      speq_pkg::SPEQ_SHIFT: begin
        if (mstr_q) begin
          sck_o_d = ~sck_o_q;
          // Sample on the rising edge, shift on the falling one, so the data line
          // never moves together with the edge the peer samples on
          if (!sck_o_q) begin
            mis_d = miso_s;
          end else begin
            shf_d = {shf_q[6:0], mis_q};
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == speq_pkg::BIT_LAST) begin
              rx_d = {shf_q[6:0], mis_q};
              rxf_d = 1'b1;
              st_d = speq_pkg::SPEQ_IDLE;
            end
          end
        end else begin
          if (cs_n_s) begin
            st_d = speq_pkg::SPEQ_IDLE;
          end else if (rise) begin
            shf_d = {shf_q[6:0], mosi_s}; // R7
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == speq_pkg::BIT_LAST) begin
              rx_d = {shf_q[6:0], mosi_s};
              rxf_d = 1'b1;
              st_d = speq_pkg::SPEQ_IDLE;
            end
          end
        end
      end
      speq_pkg::SPEQ_HANG: begin
        // Stuck until config changes or reset
        if (start_ok || !active) begin
          st_d = speq_pkg::SPEQ_IDLE;
        end
      end
      default: st_d = speq_pkg::SPEQ_IDLE;
    endcase
    if (fall) begin
      sck_prev_d = sck_s;
    end
  end

  always_ff @(posedge mclk) begin
    if (clr) begin
      st_q <= speq_pkg::SPEQ_IDLE;
      hold_q <= speq_pkg::TX_RESET;
      shf_q <= speq_pkg::TX_RESET;
      rx_q <= speq_pkg::RX_RESET;
      cnt_q <= 3'h0;
      empty_q <= 1'b1;
      rxf_q <= 1'b0;
      sck_prev_q <= 1'b0;
      sck_o_q <= 1'b0;
      cs_o_q <= 1'b1;
      en_q <= 1'b0;
      mstr_q <= 1'b0;
      mis_q <= 1'b0;
    end else begin
      st_q <= st_d;
      hold_q <= hold_d;
      shf_q <= shf_d;
      rx_q <= rx_d;
      cnt_q <= cnt_d;
      empty_q <= empty_d;
      rxf_q <= rxf_d;
      sck_prev_q <= sck_prev_d;
      sck_o_q <= sck_o_d;
      cs_o_q <= cs_o_d;
      en_q <= en_d;
      mstr_q <= mstr_d;
      mis_q <= mis_d;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (clr) begin
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      cs_n_out <= 1'b1;
      mosi_out <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      rx_data <= speq_pkg::RX_RESET;
      stat <= '{tx_holding_empty_flag: 1'b1, default: 1'b0};
    end else begin
      sck_out <= sck_o_d;
      sck_oe <= en_d & mstr_d;
      cs_n_out <= cs_o_d;
      mosi_out <= shf_d[7];
      miso_out <= shf_d[7];
      miso_oe <= en_d & ~mstr_d & ~cs_n_s;
      rx_data <= rx_d;
      stat.tx_holding_empty_flag <= empty_d;
      stat.rx_full <= rxf_d;
      stat.busy <= (st_d != speq_pkg::SPEQ_IDLE);
      stat.enabled <= en_d;
    end
  end
endmodule
`default_nettype wire

// ==== hdl/speq_pkg.sv ====
`default_nettype none
package speq_pkg;
  localparam int DATA_W = 8;
  localparam int SYNC_STAGES = 2;
  localparam logic [7:0] TX_RESET = 8'h00;
  localparam logic [7:0] RX_RESET = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef struct packed {
    logic enable;
    logic master;
    logic cs_hold_after_transfer;
    logic mode_fault_disable;
  } speq_cfg_type;

  typedef struct packed {
    logic tx_holding_empty_flag;
    logic rx_full;
    logic busy;
    logic enabled;
  } speq_stat_type;

  typedef enum logic [1:0] {
    SPEQ_IDLE = 2'b00,
    SPEQ_SHIFT = 2'b01,
    SPEQ_HANG = 2'b10
  } speq_state_type;
endpackage
`default_nettype wire

// ==== hdl/speq_sync.sv ====
`default_nettype none
module speq_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s1_d;
  logic s2_q;
  logic s2_d;

  always_comb begin
    s1_d = din;
    s2_d = s1_q;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign dout = s2_q;
endmodule
`default_nettype wire

// ==== verif/speq_asserts.sv ====
`default_nettype none
module speq_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic soft_reset_bit,
  input wire speq_pkg::speq_cfg_type cfg,
  input wire logic wr_valid,
  input wire logic cs_n_out,
  input wire logic sck_out,
  input wire speq_pkg::speq_stat_type stat
);
  // ----
  // Checks
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (rst || soft_reset_bit);
  wire logic hang = cfg.master && cfg.cs_hold_after_transfer && !cfg.mode_fault_disable;
  wire logic mt = stat.tx_holding_empty_flag;
  sequence s_go; $fell(cs_n_out) ##0 cfg.master && cfg.mode_fault_disable; endsequence
  sequence s_clk; ##[1:4] $changed(sck_out); endsequence
  a_no_start: assert property (hang && $past(hang) |-> !$fell(cs_n_out))
    else $error("start under hang");
  a_sck_quiet: assert property (hang && $past(hang) |-> $stable(sck_out))
    else $error("clock under hang");
  a_hang_busy: assert property (hang && stat.enabled && stat.busy |=> stat.busy)
    else $error("hang left");
  a_held_runs: assert property (s_go |-> s_clk)
    else $error("no clock after start");
  a_dis_flag: assert property ($fell(stat.enabled) && !$past(soft_reset_bit) && !$past(rst)
    |-> $stable(mt))
    else $error("flag moved on disable");
  a_wr_clear: assert property (wr_valid && stat.enabled && mt |=> !mt)
    else $error("write kept flag");
  a_wr_drop: assert property (wr_valid && !stat.enabled && !stat.busy |=> $stable(mt))
    else $error("write not dropped");
  a_slave_keep: assert property (stat.enabled && !cfg.master |=> stat.enabled)
    else $error("slave disabled");
  a_soft_clr: assert property (disable iff (rst) soft_reset_bit |=> cs_n_out && mt)
    else $error("soft reset state");
endmodule
bind speq_core speq_asserts u_chk (.mclk(mclk), .rst(rst), .soft_reset_bit(soft_reset_bit),
  .cfg(cfg), .wr_valid(wr_valid), .cs_n_out(cs_n_out), .sck_out(sck_out), .stat(stat));
`default_nettype wire

// ==== verif/speq_core_tb.sv ====
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t mismatch", $time); end end
module speq_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, soft_reset_bit = 0, wr_valid = 0, rd_strobe = 0;
  logic sck_in = 0, cs_n_in = 1, mosi_in = 0, miso_in, sck_out, sck_oe, cs_n_out;
  logic mosi_out, miso_out, miso_oe;
  logic [7:0] wr_data = 8'h00, rx_data, got;
  speq_pkg::speq_cfg_type cfg = 4'h0;
  speq_pkg::speq_stat_type stat;
  int error_cnt = 0, checks_done = 0;
  initial forever #5 mclk = ~mclk;
  speq_core dut_u (.mclk(mclk), .rst(rst), .soft_reset_bit(soft_reset_bit), .cfg(cfg),
    .wr_valid(wr_valid), .wr_data(wr_data), .rd_strobe(rd_strobe), .sck_in(sck_in),
    .cs_n_in(cs_n_in), .mosi_in(mosi_in), .miso_in(miso_in), .sck_out(sck_out),
    .sck_oe(sck_oe), .cs_n_out(cs_n_out), .mosi_out(mosi_out), .miso_out(miso_out),
    .miso_oe(miso_oe), .rx_data(rx_data), .stat(stat));
  speq_slave_model peer_u (.sck(sck_out), .cs_n(cs_n_out), .mosi(mosi_out), .miso(miso_in),
    .got(got));
  task conclude;
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task put(input logic [7:0] d);
    wr_data = d;
    wr_valid = 1;
    tick(1);
    wr_valid = 0;
    tick(1);
  endtask
  task sreset;
    soft_reset_bit = 1;
    tick(1);
    soft_reset_bit = 0;
    tick(1);
  endtask
  task t_master;
    int i;
    cfg = 4'hF;
    tick(2);
    put(8'hC5);
    tick(2);
    `CHK(cs_n_out, 1'b0)
    for (i = 0; i < 99 && stat.busy !== 1'b0; i++) tick(1);
    if (i == 99) begin
      error_cnt++;
      conclude();
    end
    `CHK(got, 8'hC5)
    `CHK(sck_oe, 1'b1)
    `CHK(cs_n_out, 1'b0)
    `CHK(stat.tx_holding_empty_flag, 1'b1)
  endtask
  task t_hang;
    cfg = 4'hE;
    tick(2);
    put(8'h5A);
    tick(40);
    `CHK(cs_n_out, 1'b1)
    `CHK(stat.busy, 1'b1)
    `CHK(got, 8'hC5)
  endtask
  task t_disable;
    cfg = 4'hE;
    tick(2);
    put(8'h33);
    tick(2);
    `CHK(stat.tx_holding_empty_flag, 1'b0)
    cfg.enable = 0;
    tick(3);
    `CHK(stat.enabled, 1'b0)
    `CHK(stat.tx_holding_empty_flag, 1'b0)
    sreset();
    put(8'h11);
    put(8'h22);
    tick(3);
    `CHK(stat.tx_holding_empty_flag, 1'b1)
    cfg = 4'hC;
    tick(3);
    `CHK(cs_n_out, 1'b1)
    `CHK(stat.busy, 1'b0)
    put(8'h6E);
    tick(2);
    `CHK(cs_n_out, 1'b0)
    tick(20);
    `CHK(got, 8'h6E)
    `CHK(cs_n_out, 1'b1)
  endtask
  task t_slave;
    logic [7:0] b;
    b = 8'hA5;
    cfg = 4'h8;
    tick(3);
    cs_n_in = 0;
    for (int i = 7; i >= 0; i--) begin
      mosi_in = b[i];
      tick(8);
      sck_in = 1;
      tick(8);
      sck_in = 0;
      if (i == 5) cfg.enable = 0;
      if (i == 3) `CHK(miso_oe, 1'b1)
    end
    cs_n_in = 1;
    tick(6);
    `CHK(stat.enabled, 1'b1)
    `CHK(rx_data, 8'hA5)
    `CHK(stat.rx_full, 1'b1)
    rd_strobe = 1;
    tick(1);
    rd_strobe = 0;
    `CHK(stat.rx_full, 1'b0)
    sreset();
    `CHK(stat.enabled, 1'b0)
    `CHK(miso_oe, 1'b0)
    `CHK(stat.rx_full, 1'b0)
  endtask
  initial begin
    tick(8);
    rst = 0;
    t_master();
    sreset();
    t_hang();
    sreset();
    t_disable();
    t_slave();
    conclude();
  end
endmodule
`default_nettype wire

// ==== verif/speq_slave_model.sv ====
`default_nettype none
module speq_slave_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sr = 8'h3C;
  initial got = 8'h00;
  always @(posedge sck) if (!cs_n) got <= {got[6:0], mosi};
  always @(negedge sck) if (!cs_n) sr <= {sr[6:0], ~sr[7]};
  // Released line shows the inverse, never a stale bit
  assign miso = cs_n ? ~sr[7] : sr[7];
endmodule
`default_nettype wire
